// file: shadow_xfer_cfg.svh
`ifndef SHADOW_XFER_CFG_SVH
`define SHADOW_XFER_CFG_SVH

// ----------------------------------------
// Parameter RAM window
// ----------------------------------------
`define PRAM_LO      16'h0580
`define PRAM_HI      16'h05E1
`define BASE0_LO     16'h059E
`define BASE0_HI     16'h059F
`define BASE1_LO     16'h05A0
`define BASE1_HI     16'h05A1
`define CFG_BYTE_LO  16'h05A2
`define LOAD_FIRST   16'h059E

// ----------------------------------------
// Config byte layout and reset values
// ----------------------------------------
`define CFG_TRIG_MSB 3
`define CFG_TRIG_LSB 0
`define CFG_EN_BIT   4
`define CFG_RESET    8'h00
`define BASE_RESET   16'h1000
`define CAT1_ADDR    16'h0084

`endif

// file: shadow_xfer_pkg.sv
`default_nettype none
package shadow_xfer_pkg;
	typedef enum logic [3:0]
	{
		TRIG_ALWAYS = 4'h0,
		TRIG_DIST_CLOCK_SYNC_PULSE_0,
		TRIG_DIST_CLOCK_SYNC_PULSE_1,
		TRIG_DIST_CLOCK_LATCH_IN_0,
		TRIG_DIST_CLOCK_LATCH_IN_1,
		TRIG_SOF,
		TRIG_EOF,
		TRIG_HOST_SEL,
		TRIG_HOST_DESEL,
		TRIG_CTL_SEL,
		TRIG_CTL_DESEL,
		TRIG_PRE_COPY,
		TRIG_POST_COPY,
		TRIG_PWM_ZERO,
		TRIG_NEVER,
		TRIG_ALWAYS_ALT
	} trig_src_t;
	typedef enum {SEQ_IDLE, SEQ_PRE, SEQ_SCAN, SEQ_WAIT, SEQ_POST} seq_state_t;
	typedef enum {LD_REQ, LD_WAIT, LD_DONE} load_state_t;
endpackage : shadow_xfer_pkg
`default_nettype wire

// file: seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seq_if #(parameter int N = 8, parameter int IDX_W = 3);
	logic             start;
	logic             busy;
	logic             pre;
	logic             post;
	logic             issue;
	logic             done;
	logic [IDX_W-1:0] idx;
	logic [N-1:0]     en;
	logic [N-1:0]     dir;
	logic [15:0]      base0;
	logic [15:0]      base1;
	modport seq (input start, en, dir, base0, base1,
		output busy, pre, post, issue, done, idx);
	modport ctl (output start, en, dir, base0, base1,
		input busy, pre, post, issue, done, idx);
endinterface : seq_if
`default_nettype wire

// file: pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
#(
	parameter int               WIDTH      = 6,
	parameter logic [WIDTH-1:0] RESET_LVL  = '0
)
(
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] rise,
	output var  logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] agree_q;
	logic [WIDTH-1:0] level_q;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q  <= RESET_LVL;
			sync_q  <= RESET_LVL;
			agree_q <= RESET_LVL;
			level_q <= RESET_LVL;
			rise    <= '0;
			fall    <= '0;
		end
		else
		begin
			meta_q  <= pin_in;
			sync_q  <= meta_q;
			agree_q <= sync_q;
			// Level moves only when the last two stages agree
			level_q <= (sync_q & agree_q) | (level_q & (sync_q | agree_q));
			rise    <= ~level_q & sync_q & agree_q;
			fall    <= level_q & ~sync_q & ~agree_q;
		end
	end

	property p_single_edge;
		@(posedge core_clk) disable iff (!rst_b)
		(rise != '0) |=> ((rise & $past(rise)) == '0) && ((rise & fall) == '0);
	endproperty
	a_single_edge: assert property (p_single_edge)
		else $error("edge pulse repeated");
endmodule : pin_edge_detect
`default_nettype wire

// file: copy_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module copy_sequencer
	import shadow_xfer_pkg::*;
#(
	parameter int             N        = 8,
	parameter int             IDX_W    = 3,
	parameter int             BE_W     = 4,
	parameter logic [3*N-1:0] REG_SIZE = {N{3'd4}}
)
(
	input  wire logic            core_clk,
	input  wire logic            rst_b,
	seq_if.seq                   s,
	output var  logic            ram_req,
	output var  logic            ram_we,
	output var  logic [15:0]     ram_addr,
	output var  logic [BE_W-1:0] ram_be,
	input  wire logic            ram_ack
);
	seq_state_t       state_q;
	logic [IDX_W-1:0] idx_q;
	logic [15:0]      off0_q;
	logic [15:0]      off1_q;
	logic [2:0]       size;
	logic             last;

	function automatic logic [15:0] slot_of(input logic [2:0] sz);
		logic [3:0] t;
		t = {1'b0, sz} + 4'h3;
		return {12'h000, t[3:2], 2'b00};
	endfunction : slot_of

	function automatic logic [BE_W-1:0] be_of(input logic [2:0] sz);
		logic [BE_W-1:0] b;
		b = '0;
		for (int k = 0; k < BE_W; k++)
			b[k] = (k < int'(sz));
		return b;
	endfunction : be_of

	assign size    = REG_SIZE[3*idx_q +: 3];
	assign last    = (idx_q == IDX_W'(N-1));
	assign s.idx   = idx_q;
	assign s.busy  = (state_q != SEQ_IDLE);
	assign s.pre   = (state_q == SEQ_PRE);
	assign s.post  = (state_q == SEQ_POST);
	assign s.issue = (state_q == SEQ_SCAN) && s.en[idx_q];
	assign s.done  = (state_q == SEQ_WAIT) && ram_ack;

	// ----------------------------------------
	// Walk of enabled registers
	// ----------------------------------------
	// one pass copies every enabled register
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= SEQ_IDLE;
			idx_q   <= '0;
		end
		else
		begin
			case (state_q)
				SEQ_IDLE: if (s.start) state_q <= SEQ_PRE;
				SEQ_PRE:
				begin
					idx_q   <= '0;
					state_q <= SEQ_SCAN;
				end
				SEQ_SCAN:
				begin
					if (s.en[idx_q])
						state_q <= SEQ_WAIT;
					else if (last)
						state_q <= SEQ_POST;
					else
						idx_q <= idx_q + 1'b1;
				end
				SEQ_WAIT:
				begin
					if (ram_ack && last)
						state_q <= SEQ_POST;
					else if (ram_ack)
					begin
						idx_q   <= idx_q + 1'b1;
						state_q <= SEQ_SCAN;
					end
				end
				default: state_q <= SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ram_req  <= 1'b0;
			ram_we   <= 1'b0;
			ram_addr <= '0;
			ram_be   <= '0;
			off0_q   <= '0;
			off1_q   <= '0;
		end
		else if (s.pre)
		begin
			off0_q <= '0;
			off1_q <= '0;
		end
		else if (s.issue)
		begin
			ram_req <= 1'b1;
			ram_we  <= s.dir[idx_q];
			ram_be  <= be_of(size);
			if (s.dir[idx_q])
			begin
				ram_addr <= s.base1 + off1_q;
				off1_q   <= off1_q + slot_of(size);
			end
			else
			begin
				ram_addr <= s.base0 + off0_q;
				off0_q   <= off0_q + slot_of(size);
			end
		end
		else if (s.done)
			ram_req <= 1'b0;
	end

	sequence s_copy_end;
		##[1:600] s.post;
	endsequence

	property p_one_pass;
		@(posedge core_clk) disable iff (!rst_b)
		s.pre |-> s_copy_end;
	endproperty
	a_one_pass: assert property (p_one_pass)
		else $error("copy pass did not finish");

	property p_pre_first;
		@(posedge core_clk) disable iff (!rst_b)
		s.start && !s.busy |=> s.pre && !ram_req;
	endproperty
	a_pre_first: assert property (p_pre_first)
		else $error("pre-copy trigger missing");

	property p_slot_align;
		@(posedge core_clk) disable iff (!rst_b)
		$rose(ram_req) |-> ram_addr[1:0] == (ram_we ? s.base1[1:0] : s.base0[1:0]);
	endproperty
	a_slot_align: assert property (p_slot_align)
		else $error("slot not 4-byte aligned");
endmodule : copy_sequencer
`default_nettype wire

// file: shadow_xfer.sv
`timescale 1ns/1ps
`default_nettype none
`include "shadow_xfer_cfg.svh"
module shadow_xfer
	import shadow_xfer_pkg::*;
#(
	parameter int                    NUM_REGS  = 8,
	parameter int                    IDX_W     = 3,
	parameter int                    DATA_W    = 32,
	parameter logic [NUM_REGS-1:0]   REG_DIR   = 8'hF0,
	parameter logic [3*NUM_REGS-1:0] REG_SIZE  = {NUM_REGS{3'd4}},
	parameter logic [15:0]           CAT1_ADDR = `CAT1_ADDR
)
(
	input  wire logic                       core_clk,
	input  wire logic                       rst_b,
	input  wire logic                       dist_clock_sync_pulse_0,
	input  wire logic                       dist_clock_sync_pulse_1,
	input  wire logic                       dist_clock_latch_in_0,
	input  wire logic                       dist_clock_latch_in_1,
	input  wire logic                       host_port_chip_select_n,
	input  wire logic                       control_port_chip_select_n,
	input  wire logic                       frame_start,
	input  wire logic                       frame_end,
	input  wire logic                       pwm_zero_pulse,
	input  wire logic                       param_wr,
	input  wire logic [15:0]                param_addr,
	input  wire logic [7:0]                 param_wdata,
	output var  logic                       cfg_mem_req,
	output var  logic [15:0]                cfg_mem_addr,
	input  wire logic [7:0]                 cfg_mem_rdata,
	input  wire logic                       cfg_mem_ack,
	output var  logic                       config_loaded,
	input  wire logic                       ctl_wr,
	input  wire logic                       ctl_rd,
	input  wire logic [IDX_W-1:0]           ctl_idx,
	input  wire logic [DATA_W-1:0]          ctl_wdata,
	output var  logic [DATA_W-1:0]          ctl_rdata,
	output var  logic                       ctl_rvalid,
	input  wire logic                       bridge_start,
	output var  logic                       bridge_busy,
	output var  logic                       ram_req,
	output var  logic                       ram_we,
	output var  logic [15:0]                ram_addr,
	output var  logic [DATA_W/8-1:0]        ram_be,
	output var  logic [DATA_W-1:0]          ram_wdata,
	input  wire logic [DATA_W-1:0]          ram_rdata,
	input  wire logic                       ram_ack,
	output var  logic [NUM_REGS*DATA_W-1:0] func_wr_data,
	input  wire logic [NUM_REGS*DATA_W-1:0] func_rd_data
);
	localparam int         LOAD_LEN = 4 + NUM_REGS;
	localparam logic [5:0] PIN_IDLE = 6'h30;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0]        cfg_q    [NUM_REGS];
	logic [15:0]       base0_q;
	logic [15:0]       base1_q;
	logic [DATA_W-1:0] live_q   [NUM_REGS];
	logic [DATA_W-1:0] shadow_q [NUM_REGS];
	load_state_t       ld_state_q;
	logic [6:0]        ld_cnt_q;
	logic              pw_en;
	logic [15:0]       pw_addr;
	logic [7:0]        pw_data;
	logic [5:0]        pin_rise;
	logic [5:0]        pin_fall;
	logic [2:0]        local_prev_q;
	logic [2:0]        local_rise;
	logic [15:0]       ev_vec;
	logic [NUM_REGS-1:0] hit;

	seq_if #(.N(NUM_REGS), .IDX_W(IDX_W)) s ();

	function automatic logic [3:0] cfg_trig(input logic [7:0] c);
		return c[`CFG_TRIG_MSB:`CFG_TRIG_LSB];
	endfunction : cfg_trig

	function automatic logic cfg_en(input logic [7:0] c);
		return c[`CFG_EN_BIT];
	endfunction : cfg_en

	// ----------------------------------------
	// Trigger sources
	// ----------------------------------------
	pin_edge_detect #(
		.WIDTH     (6),
		.RESET_LVL (PIN_IDLE)
	) u_pins (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pin_in   ({control_port_chip_select_n, host_port_chip_select_n,
			dist_clock_latch_in_1, dist_clock_latch_in_0,
			dist_clock_sync_pulse_1, dist_clock_sync_pulse_0}),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			local_prev_q <= '0;
		else
			local_prev_q <= {pwm_zero_pulse, frame_end, frame_start};
	end
	assign local_rise = {pwm_zero_pulse, frame_end, frame_start} & ~local_prev_q;

	always_comb
	begin
		ev_vec = '0;
		ev_vec[TRIG_ALWAYS]     = 1'b1;
		ev_vec[TRIG_ALWAYS_ALT] = 1'b1;
		ev_vec[TRIG_DIST_CLOCK_SYNC_PULSE_0]      = pin_rise[0];
		ev_vec[TRIG_DIST_CLOCK_SYNC_PULSE_1]      = pin_rise[1];
		ev_vec[TRIG_DIST_CLOCK_LATCH_IN_0]     = pin_rise[2];
		ev_vec[TRIG_DIST_CLOCK_LATCH_IN_1]     = pin_rise[3];
		ev_vec[TRIG_SOF]        = local_rise[0];
		ev_vec[TRIG_EOF]        = local_rise[1];
		ev_vec[TRIG_HOST_SEL]   = pin_fall[4];
		ev_vec[TRIG_HOST_DESEL] = pin_rise[4];
		ev_vec[TRIG_CTL_SEL]    = pin_fall[5];
		ev_vec[TRIG_CTL_DESEL]  = pin_rise[5];
		ev_vec[TRIG_PRE_COPY]   = s.pre;
		ev_vec[TRIG_POST_COPY]  = s.post;
		ev_vec[TRIG_PWM_ZERO]   = local_rise[2];
		ev_vec[TRIG_NEVER]      = 1'b0;
	end

	// ----------------------------------------
	// Config load and run-time writes
	// ----------------------------------------
	// load from category 1 block
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ld_state_q   <= LD_REQ;
			ld_cnt_q     <= '0;
			cfg_mem_req  <= 1'b0;
			cfg_mem_addr <= '0;
		end
		else
		begin
			case (ld_state_q)
				LD_REQ:
				begin
					cfg_mem_req  <= 1'b1;
					cfg_mem_addr <= CAT1_ADDR + (`LOAD_FIRST - `PRAM_LO) + {9'h000, ld_cnt_q};
					ld_state_q   <= LD_WAIT;
				end
				LD_WAIT:
				begin
					if (cfg_mem_ack)
					begin
						cfg_mem_req <= 1'b0;
						ld_cnt_q    <= ld_cnt_q + 1'b1;
						if (ld_cnt_q == 7'(LOAD_LEN - 1))
							ld_state_q <= LD_DONE;
						else
							ld_state_q <= LD_REQ;
					end
				end
				default: ld_state_q <= LD_DONE;
			endcase
		end
	end
	assign config_loaded = (ld_state_q == LD_DONE);

	// Run-time writes wait for the load; loss during load is preferred to a race
	always_comb
	begin
		if (ld_state_q == LD_WAIT)
		begin
			pw_en   = cfg_mem_ack;
			pw_addr = `LOAD_FIRST + {9'h000, ld_cnt_q};
			pw_data = cfg_mem_rdata;
		end
		else
		begin
			pw_en   = param_wr && config_loaded;
			pw_addr = param_addr;
			pw_data = param_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			base0_q <= `BASE_RESET;
			base1_q <= `BASE_RESET;
			for (int k = 0; k < NUM_REGS; k++)
				cfg_q[k] <= `CFG_RESET;
		end
		else if (pw_en)
		begin
			if (pw_addr == `BASE0_LO)
				base0_q[7:0] <= pw_data;
			else if (pw_addr == `BASE0_HI)
				base0_q[15:8] <= pw_data;
			else if (pw_addr == `BASE1_LO)
				base1_q[7:0] <= pw_data;
			else if (pw_addr == `BASE1_HI)
				base1_q[15:8] <= pw_data;
			else if (pw_addr >= `CFG_BYTE_LO && pw_addr <= `PRAM_HI
				&& pw_addr < `CFG_BYTE_LO + 16'(NUM_REGS))
				cfg_q[IDX_W'(pw_addr - `CFG_BYTE_LO)] <= pw_data;
		end
	end

	// ----------------------------------------
	// Memory bridge pass
	// ----------------------------------------
	assign s.start     = bridge_start && config_loaded;
	assign s.dir       = REG_DIR;
	assign s.base0     = base0_q;
	assign s.base1     = base1_q;
	assign bridge_busy = s.busy;

	copy_sequencer #(
		.N        (NUM_REGS),
		.IDX_W    (IDX_W),
		.BE_W     (DATA_W/8),
		.REG_SIZE (REG_SIZE)
	) u_seq (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.s        (s.seq),
		.ram_req  (ram_req),
		.ram_we   (ram_we),
		.ram_addr (ram_addr),
		.ram_be   (ram_be),
		.ram_ack  (ram_ack)
	);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ram_wdata <= '0;
		else if (s.issue)
			ram_wdata <= shadow_q[s.idx];
	end

	// ----------------------------------------
	// Control port read-back
	// ----------------------------------------
	// mapped regs still readable
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctl_rdata  <= '0;
			ctl_rvalid <= 1'b0;
		end
		else
		begin
			ctl_rvalid <= ctl_rd;
			if (ctl_rd)
				ctl_rdata <= live_q[ctl_idx];
		end
	end

	// ----------------------------------------
	// Per-register live and shadow copies
	// ----------------------------------------
	for (genvar i = 0; i < NUM_REGS; i++)
	begin : g_reg
		assign s.en[i] = cfg_en(cfg_q[i]);
		assign hit[i]  = cfg_en(cfg_q[i]) && ev_vec[cfg_trig(cfg_q[i])];
		assign func_wr_data[i*DATA_W +: DATA_W] = live_q[i];

		always_ff @(posedge core_clk or negedge rst_b)
		begin
			if (!rst_b)
				live_q[i] <= '0;
			else if (REG_DIR[i])
				live_q[i] <= func_rd_data[i*DATA_W +: DATA_W];
			else if (hit[i])
				live_q[i] <= shadow_q[i];
			else if (ctl_wr && ctl_idx == IDX_W'(i) && !s.en[i])
				live_q[i] <= ctl_wdata;
		end

		always_ff @(posedge core_clk or negedge rst_b)
		begin
			if (!rst_b)
				shadow_q[i] <= '0;
			else if (REG_DIR[i] && hit[i])
				shadow_q[i] <= live_q[i];
			else if (!REG_DIR[i] && s.done && s.idx == IDX_W'(i))
				shadow_q[i] <= ram_rdata;
		end

		property p_ctl_write;
			@(posedge core_clk) disable iff (!rst_b)
			!REG_DIR[i] && !s.en[i] && ctl_wr && ctl_idx == IDX_W'(i)
				|=> live_q[i] == $past(ctl_wdata);
		endproperty
		a_ctl_write: assert property (p_ctl_write)
			else $error("control write to unmapped register lost");

		property p_debug_hold;
			@(posedge core_clk) disable iff (!rst_b)
			s.en[i] && cfg_trig(cfg_q[i]) == TRIG_NEVER
				|=> (REG_DIR[i] ? $stable(shadow_q[i]) : $stable(live_q[i]));
		endproperty
		a_debug_hold: assert property (p_debug_hold)
			else $error("mapped register changed under never trigger");

		property p_transparent;
			@(posedge core_clk) disable iff (!rst_b)
			REG_DIR[i] && s.en[i] && (cfg_trig(cfg_q[i]) == TRIG_ALWAYS
				|| cfg_trig(cfg_q[i]) == TRIG_ALWAYS_ALT) ##1 REG_DIR[i]
				|-> shadow_q[i] == $past(live_q[i]);
		endproperty
		a_transparent: assert property (p_transparent)
			else $error("transparent shadow did not follow register");

		property p_dist_clock_sync_pulse_0_only;
			@(posedge core_clk) disable iff (!rst_b)
			REG_DIR[i] && s.en[i] && cfg_trig(cfg_q[i]) == TRIG_DIST_CLOCK_SYNC_PULSE_0 && !pin_rise[0]
				|=> $stable(shadow_q[i]);
		endproperty
		a_dist_clock_sync_pulse_0_only: assert property (p_dist_clock_sync_pulse_0_only)
			else $error("shadow captured without sync pulse 0 edge");
	end
endmodule : shadow_xfer
`default_nettype wire

// file: bridge_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_ram_model
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        slow,
	input  wire logic        ram_req,
	input  wire logic        ram_we,
	input  wire logic [15:0] ram_addr,
	input  wire logic [3:0]  ram_be,
	input  wire logic [31:0] ram_wdata,
	output var  logic [31:0] ram_rdata,
	output var  logic        ram_ack,
	input  wire logic        cfg_mem_req,
	input  wire logic [15:0] cfg_mem_addr,
	output var  logic [7:0]  cfg_mem_rdata,
	output var  logic        cfg_mem_ack
);
	logic [31:0] mem [logic [15:0]];
	logic [7:0]  cfg_rom [logic [15:0]];
	logic [31:0] word;
	logic [2:0]  wait_q;
	int          k;

	// ----------------------------------------
	// Process RAM behind the bridge
	// ----------------------------------------
	// Slow mode holds each access five cycles longer, to stretch the scan
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ram_ack   <= 1'b0;
			wait_q    <= 3'h0;
			ram_rdata <= 32'h0000_0000;
		end
		else if (ram_ack || !ram_req)
		begin
			// Released data lines toggle so a stale word is never mistaken
			ram_ack   <= 1'b0;
			wait_q    <= 3'h0;
			ram_rdata <= ~ram_rdata;
		end
		else if (wait_q >= (slow ? 3'h5 : 3'h0))
		begin
			ram_ack <= 1'b1;
			if (ram_we)
			begin
				word = mem.exists(ram_addr) ? mem[ram_addr] : 32'h0000_0000;
				for (k = 0; k < 4; k++)
					if (ram_be[k])
						word[8*k +: 8] = ram_wdata[8*k +: 8];
				mem[ram_addr] = word;
			end
			else
				ram_rdata <= mem.exists(ram_addr) ? mem[ram_addr] : {ram_addr, ~ram_addr};
		end
		else
			wait_q <= wait_q + 3'h1;
	end

	// ----------------------------------------
	// Configuration memory
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_mem_ack   <= 1'b0;
			cfg_mem_rdata <= 8'h00;
		end
		else if (cfg_mem_ack || !cfg_mem_req)
		begin
			cfg_mem_ack   <= 1'b0;
			cfg_mem_rdata <= ~cfg_mem_rdata;
		end
		else
		begin
			cfg_mem_ack   <= 1'b1;
			cfg_mem_rdata <= cfg_rom.exists(cfg_mem_addr) ? cfg_rom[cfg_mem_addr] : 8'h00;
		end
	end
endmodule : bridge_ram_model
`default_nettype wire

// file: test_function_register_shadow_transfer.sv
`timescale 1ns/1ps
`default_nettype none
`include "shadow_xfer_cfg.svh"
module test_function_register_shadow_transfer;
	logic         core_clk, rst_b, slow, param_wr, ctl_wr, ctl_rd, bridge_start;
	logic [8:0]   pin_act;
	logic [15:0]  param_addr, cfg_mem_addr, ram_addr;
	logic [7:0]   param_wdata, cfg_mem_rdata;
	logic [2:0]   ctl_idx;
	logic [31:0]  ctl_wdata, ctl_rdata, ram_wdata, ram_rdata, exp, sent, got, a, b;
	logic [255:0] rd_bus, func_wr_data;
	logic         cfg_mem_req, cfg_mem_ack, config_loaded, ctl_rvalid;
	logic         bridge_busy, ram_req, ram_we, ram_ack;
	logic [3:0]   ram_be;
	int           num_errors, n_tests, i, c, p;
	int           pin_of [16];

	shadow_xfer DUT (.core_clk(core_clk), .rst_b(rst_b),
		.dist_clock_sync_pulse_0(pin_act[0]), .dist_clock_sync_pulse_1(pin_act[1]),
		.dist_clock_latch_in_0(pin_act[2]), .dist_clock_latch_in_1(pin_act[3]),
		.frame_start(pin_act[4]), .frame_end(pin_act[5]),
		.host_port_chip_select_n(~pin_act[6]), .control_port_chip_select_n(~pin_act[7]),
		.pwm_zero_pulse(pin_act[8]), .param_wr(param_wr), .param_addr(param_addr),
		.param_wdata(param_wdata), .cfg_mem_req(cfg_mem_req), .cfg_mem_addr(cfg_mem_addr),
		.cfg_mem_rdata(cfg_mem_rdata), .cfg_mem_ack(cfg_mem_ack),
		.config_loaded(config_loaded), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_idx(ctl_idx),
		.ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ctl_rvalid(ctl_rvalid),
		.bridge_start(bridge_start), .bridge_busy(bridge_busy), .ram_req(ram_req),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_be(ram_be), .ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata), .ram_ack(ram_ack), .func_wr_data(func_wr_data),
		.func_rd_data(rd_bus));

	bridge_ram_model P (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .ram_req(ram_req),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_be(ram_be), .ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata), .ram_ack(ram_ack), .cfg_mem_req(cfg_mem_req),
		.cfg_mem_addr(cfg_mem_addr), .cfg_mem_rdata(cfg_mem_rdata),
		.cfg_mem_ack(cfg_mem_ack));

	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
			num_errors++;
		end
	endtask : check

	task automatic print_verdict;
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic ctl_write(input logic [2:0] idx, input logic [31:0] d);
		@(posedge core_clk);
		ctl_wr    <= 1'b1;
		ctl_idx   <= idx;
		ctl_wdata <= d;
		@(posedge core_clk);
		ctl_wr <= 1'b0;
		#1;
	endtask : ctl_write

	task automatic ctl_read(input logic [2:0] idx, output logic [31:0] d);
		@(posedge core_clk);
		ctl_rd  <= 1'b1;
		ctl_idx <= idx;
		@(posedge core_clk);
		ctl_rd <= 1'b0;
		#1;
		d = (ctl_rvalid === 1'b1) ? ctl_rdata : 'x;
	endtask : ctl_read

	task automatic param_write(input logic [15:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		param_wr    <= 1'b1;
		param_addr  <= ad;
		param_wdata <= d;
		@(posedge core_clk);
		param_wr <= 1'b0;
	endtask : param_write

	task automatic run_pass(input logic s);
		int n;
		@(posedge core_clk);
		slow         <= s;
		bridge_start <= 1'b1;
		@(posedge core_clk);
		bridge_start <= 1'b0;
		for (n = 0; n < 900; n++)
		begin
			@(posedge core_clk);
			#1;
			if (bridge_busy === 1'b0)
				break;
		end
		if (n == 900)
		begin
			num_errors++;
			print_verdict();
		end
	endtask : run_pass

	// Pin goes active with value a on register 4, inactive with value b
	task automatic pulse_pin(input int pn, input logic [31:0] va, input logic [31:0] vb);
		@(posedge core_clk);
		rd_bus[128 +: 32] <= va;
		repeat (3) @(posedge core_clk);
		pin_act[pn] <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd_bus[128 +: 32] <= vb;
		repeat (3) @(posedge core_clk);
		pin_act[pn] <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask : pulse_pin

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rst_b, slow, param_wr, ctl_wr, ctl_rd, bridge_start} = 6'b0;
		{pin_act, param_addr, param_wdata, ctl_idx, ctl_wdata} = '0;
		rd_bus = '0;
		rd_bus[160 +: 32] = 32'h5555_AAAA;
		num_errors = 0;
		n_tests = 0;
		pin_of = '{-1, 0, 1, 2, 3, 4, 5, 6, 6, 7, 7, -1, -1, 8, -1, -1};
		// Bases 2000h and 3000h; reg0 mapped on latch 0, regs 4 and 5 mapped transparent
		P.cfg_rom[`CAT1_ADDR + 16'h001F] = 8'h20;
		P.cfg_rom[`CAT1_ADDR + 16'h0021] = 8'h30;
		P.cfg_rom[`CAT1_ADDR + 16'h0022] = 8'h13;
		P.cfg_rom[`CAT1_ADDR + 16'h0026] = 8'h10;
		P.cfg_rom[`CAT1_ADDR + 16'h0027] = 8'h10;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		for (i = 0; i < 300 && config_loaded !== 1'b1; i++)
			@(posedge core_clk);
		check("config loaded", {31'h0, config_loaded}, 32'h1);
		if (config_loaded !== 1'b1)
			print_verdict();
		ctl_write(3'h1, 32'h1234_5678);
		check("unmapped live reg", func_wr_data[32 +: 32], 32'h1234_5678);
		ctl_read(3'h1, got);
		check("unmapped read", got, 32'h1234_5678);
		ctl_write(3'h0, 32'hDEAD_BEEF);
		check("mapped live reg", func_wr_data[31:0], 32'h0000_0000);
		ctl_read(3'h0, got);
		check("mapped read", got, 32'h0000_0000);
		P.mem[16'h2000] = 32'h5A5A_0001;
		run_pass(1'b1);
		check("write reg before trigger", func_wr_data[31:0], 32'h0000_0000);
		pulse_pin(2, 32'h0, 32'h0);
		check("write reg after latch", func_wr_data[31:0], 32'h5A5A_0001);
		param_write(16'h05A0, 8'h00);
		param_write(16'h05A1, 8'h31);
		exp = 32'h0;
		for (c = 0; c < 16; c++)
		begin
			// Unused bits 7:5 set on purpose; bit 4 keeps the register mapped
			param_write(16'h05A6, {4'hF, c[3:0]});
			for (p = 0; p < 9; p++)
			begin
				a = {16'hA000, c[7:0], p[7:0]};
				b = {16'hB000, c[7:0], p[7:0]};
				pulse_pin(p, a, b);
				if (pin_of[c] == p)
					exp = (c == 8 || c == 10) ? b : a;
			end
			@(posedge core_clk);
			rd_bus[128 +: 32] <= {16'hC000, c[15:0]};
			repeat (3) @(posedge core_clk);
			sent = (c == 0 || c == 11 || c == 15) ? {16'hC000, c[15:0]} : exp;
			run_pass(c[0]);
			got = P.mem[16'h3100];
			check("read reg", got, sent);
			if (c == 0 || c == 11 || c == 12 || c == 15)
				exp = {16'hC000, c[15:0]};
		end
		check("second read reg", P.mem[16'h3104], 32'h5555_AAAA);
		print_verdict();
	end
endmodule : test_function_register_shadow_transfer
`default_nettype wire
